/* File: src/wdrt_pkg.sv */
// wdrt_pkg: constants for the watchdog reset and wake-up timer.
// assumes a 125 MHz system clock; watchdog ticks come from a divider.
package wdrt_pkg;

  // control register field positions
  localparam int unsigned CLR_BIT = 0;
  localparam int unsigned RSF_BIT = 2;
  localparam int unsigned TOF_BIT = 3;
  localparam int unsigned WKE_BIT = 4;
  localparam int unsigned IRQE_BIT = 6;
  localparam int unsigned EN_BIT = 7;
  localparam int unsigned SEL_LO = 8;
  localparam int unsigned SEL_HI = 10;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // counter geometry
  localparam int unsigned CNT_W = 18;
  localparam int unsigned SEL_BASE_EXP = 4;

  // timing in watchdog clock periods
  localparam int unsigned GRACE_TICKS = 1024;
  localparam int unsigned RST_TICKS = 63;
  localparam logic [10:0] GRACE_LAST = 11'(GRACE_TICKS - 1);
  localparam logic [5:0] RST_LAST = 6'(RST_TICKS - 1);

  // watchdog clock derived from the system clock
  localparam int unsigned SYS_CLK_HZ = 125_000_000;
  localparam int unsigned WD_CLK_HZ = 10_000;
  localparam int unsigned TICK_DIV = SYS_CLK_HZ / WD_CLK_HZ;

  typedef enum logic [2:0] {
    WDRT_COUNT = 3'b001,
    WDRT_GRACE = 3'b010,
    WDRT_RESET = 3'b100
  } wdrt_state_t;

  // mask of low bits that must all be one at the time-out point
  function automatic logic [CNT_W-1:0] sel_mask(input logic [2:0] sel);
    logic [4:0] n;
    n = 5'(SEL_BASE_EXP) + {1'b0, sel, 1'b0};
    sel_mask = CNT_W'((19'h1 << n) - 19'h1);
  endfunction

endpackage

/* File: src/wdrt_top.sv */
// wdrt_top: watchdog timer with time-out flag, grace delay, cpu reset
// and power-down wake-up. assumes a single-cycle control write port
// driven from logic on mclk_i, and a power-down level on the same clock.
`timescale 1ns/1ps

// Function
// - 18-bit counter counts up each watchdog tick outside cpu reset
// - enable bit 7 starts the counter
// - select field picks 2^4..2^18 interval
// - time-out sets flag; irq when enabled
// - time-out starts 1024-tick grace delay
// - clear bit resets counter, self-clears
// - grace expiry sets reset flag, resets cpu
// - cpu reset lasts 63 watchdog ticks
// - reset flag survives watchdog reset
// - time-out wakes chip in power-down
// - watchdog clock runs during power-down
module wdrt_top #(
  parameter int unsigned TICK_DIV = wdrt_pkg::TICK_DIV
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // control register access
  input wire logic ctrl_wr_i,
  input wire logic [31:0] ctrl_wdata_i,
  output logic [31:0] ctrl_rdata_o,
  // system status
  input wire logic power_down_i,
  // watchdog outputs
  output logic irq_o,
  output logic cpu_reset_o,
  output logic wakeup_o
);

  logic [13:0] div_reg;
  logic tick;
  logic enable_reg;
  logic irq_en_reg;
  logic wake_en_reg;
  logic [2:0] sel_reg;
  logic clear_reg;
  logic tof_reg;
  logic rsf_reg;
  logic [wdrt_pkg::CNT_W-1:0] cnt_reg;
  logic [10:0] grace_reg;
  logic [5:0] rst_cnt_reg;
  wdrt_pkg::wdrt_state_t state_reg;
  logic timeout;
  logic grace_done;
  logic rst_done;

  // free-running tick divider, never gated by power-down
  assign tick = (div_reg == 14'(TICK_DIV - 1));

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      div_reg <= '0;
    else if (tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 14'h1;
  end

  // one time-out per count phase; grace and cpu reset hold it off
  assign timeout = tick && enable_reg && !clear_reg
    && (state_reg == wdrt_pkg::WDRT_COUNT)
    && ((cnt_reg & wdrt_pkg::sel_mask(sel_reg))
        == wdrt_pkg::sel_mask(sel_reg));
  assign grace_done = tick && enable_reg && !clear_reg
    && (state_reg == wdrt_pkg::WDRT_GRACE)
    && (grace_reg == wdrt_pkg::GRACE_LAST);
  assign rst_done = tick && (state_reg == wdrt_pkg::WDRT_RESET)
    && (rst_cnt_reg == wdrt_pkg::RST_LAST);

  // control bits
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      enable_reg <= wdrt_pkg::CTRL_RESET[wdrt_pkg::EN_BIT];
      irq_en_reg <= wdrt_pkg::CTRL_RESET[wdrt_pkg::IRQE_BIT];
      wake_en_reg <= wdrt_pkg::CTRL_RESET[wdrt_pkg::WKE_BIT];
      sel_reg <= wdrt_pkg::CTRL_RESET[wdrt_pkg::SEL_HI:wdrt_pkg::SEL_LO];
    end
    else if (ctrl_wr_i)
    begin
      enable_reg <= ctrl_wdata_i[wdrt_pkg::EN_BIT];
      irq_en_reg <= ctrl_wdata_i[wdrt_pkg::IRQE_BIT];
      wake_en_reg <= ctrl_wdata_i[wdrt_pkg::WKE_BIT];
      sel_reg <= ctrl_wdata_i[wdrt_pkg::SEL_HI:wdrt_pkg::SEL_LO];
    end
  end

  // counter-clear bit, dropped by hardware once the counter is reset
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      clear_reg <= 1'b0;
    else if (ctrl_wr_i && ctrl_wdata_i[wdrt_pkg::CLR_BIT])
      clear_reg <= 1'b1;
    else
      clear_reg <= 1'b0;
  end

  // up-counter
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_reg <= '0;
    else if (clear_reg || rst_done)
      cnt_reg <= '0;
    else if (tick && enable_reg && state_reg != wdrt_pkg::WDRT_RESET)
      cnt_reg <= cnt_reg + 18'h1;
  end

  // sequencing: count, grace delay, cpu reset
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= wdrt_pkg::WDRT_COUNT;
      grace_reg <= '0;
      rst_cnt_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        wdrt_pkg::WDRT_COUNT:
        begin
          grace_reg <= '0;
          if (timeout)
            state_reg <= wdrt_pkg::WDRT_GRACE;
        end
        wdrt_pkg::WDRT_GRACE:
        begin
          // a clear landing on the expiry tick itself still aborts the grace
          if (clear_reg || !enable_reg)
            state_reg <= wdrt_pkg::WDRT_COUNT;
          else if (grace_done)
          begin
            state_reg <= wdrt_pkg::WDRT_RESET;
            rst_cnt_reg <= '0;
          end
          else if (tick)
            grace_reg <= grace_reg + 11'h1;
        end
        wdrt_pkg::WDRT_RESET:
        begin
          if (rst_done)
            state_reg <= wdrt_pkg::WDRT_COUNT;
          else if (tick)
            rst_cnt_reg <= rst_cnt_reg + 6'h1;
        end
      endcase
    end
  end

  // sticky flags: set wins over write-one clear
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      tof_reg <= 1'b0;
    else if (timeout)
      tof_reg <= 1'b1;
    else if (ctrl_wr_i && ctrl_wdata_i[wdrt_pkg::TOF_BIT])
      tof_reg <= 1'b0;
  end

  // the external reset or a write-one clears this, not the cpu reset it causes
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rsf_reg <= 1'b0;
    else if (grace_done)
      rsf_reg <= 1'b1;
    else if (ctrl_wr_i && ctrl_wdata_i[wdrt_pkg::RSF_BIT])
      rsf_reg <= 1'b0;
  end

  // registered outputs; irq follows the time-out tick, in step with the flag
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_o <= 1'b0;
      cpu_reset_o <= 1'b0;
      wakeup_o <= 1'b0;
    end
    else
    begin
      irq_o <= (tof_reg || timeout) && irq_en_reg;
      cpu_reset_o <= (grace_done || state_reg == wdrt_pkg::WDRT_RESET)
        && !rst_done;
      wakeup_o <= timeout && power_down_i && wake_en_reg;
    end
  end

  // read image, one cycle behind the registers
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_rdata_o <= wdrt_pkg::CTRL_RESET;
    else
    begin
      ctrl_rdata_o <= '0;
      ctrl_rdata_o[wdrt_pkg::SEL_HI:wdrt_pkg::SEL_LO] <= sel_reg;
      ctrl_rdata_o[wdrt_pkg::EN_BIT] <= enable_reg;
      ctrl_rdata_o[wdrt_pkg::IRQE_BIT] <= irq_en_reg;
      ctrl_rdata_o[wdrt_pkg::WKE_BIT] <= wake_en_reg;
      ctrl_rdata_o[wdrt_pkg::TOF_BIT] <= tof_reg;
      ctrl_rdata_o[wdrt_pkg::RSF_BIT] <= rsf_reg;
      ctrl_rdata_o[wdrt_pkg::CLR_BIT] <= clear_reg;
    end
  end

endmodule

/* File: dv/wdrt_top_asserts.sv */
// wdrt_top_asserts: port checks for the watchdog timer.
// assumes it is bound to wdrt_top; flags are seen through ctrl_rdata_o.
`timescale 1ns/1ps
module wdrt_top_asserts #(
  parameter int unsigned TICK_DIV = wdrt_pkg::TICK_DIV
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic ctrl_wr_i,
  input wire logic [31:0] ctrl_wdata_i,
  input wire logic [31:0] ctrl_rdata_o,
  input wire logic power_down_i,
  input wire logic irq_o,
  input wire logic cpu_reset_o,
  input wire logic wakeup_o
);
  int rc;
  int gc;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // cycles in cpu reset, cycles of flag before reset
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rc <= 0;
      gc <= 0;
    end
    else
    begin
      rc <= cpu_reset_o ? rc + 1 : 0;
      gc <= (ctrl_rdata_o[3] && !cpu_reset_o) ? gc + 1 : 0;
    end
  end
  // irq rises with the flag's setting edge, so the image lags it by one
  property p_irq; $past(irq_o) ==
    (($past(ctrl_rdata_o[3]) | ctrl_rdata_o[3]) & $past(ctrl_rdata_o[6]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_len; $fell(cpu_reset_o) |-> rc == 63 * TICK_DIV; endproperty
  a_len: assert property (p_len) else $error("reset length");
  property p_grace; $rose(cpu_reset_o) |->
    gc >= 1024 * TICK_DIV - 4 && gc <= 1024 * TICK_DIV + 2; endproperty
  a_grace: assert property (p_grace) else $error("grace length");
  property p_rsf; $rose(cpu_reset_o) |-> ##[0:2] ctrl_rdata_o[2]; endproperty
  a_rsf: assert property (p_rsf) else $error("reset flag unset");
  property p_keep; $fell(cpu_reset_o) |-> ctrl_rdata_o[2]; endproperty
  a_keep: assert property (p_keep) else $error("reset flag lost");
  property p_clr; ctrl_rdata_o[0] |=> !ctrl_rdata_o[0]; endproperty
  a_clr: assert property (p_clr) else $error("clear stuck");
  property p_wake; wakeup_o |-> power_down_i && ctrl_rdata_o[4] ##1 !wakeup_o;
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake-up");
  // the enable that allowed the time-out shows one image earlier
  property p_en; $rose(ctrl_rdata_o[3]) |-> $past(ctrl_rdata_o[7]);
  endproperty
  a_en: assert property (p_en) else $error("time-out when off");
endmodule
bind wdrt_top wdrt_top_asserts #(.TICK_DIV(TICK_DIV)) wdrt_top_asserts_inst (
  .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ctrl_wr_i(ctrl_wr_i),
  .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
  .power_down_i(power_down_i), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o),
  .wakeup_o(wakeup_o)
);

/* File: dv/tb_watchdog_reset_wakeup_timer.sv */
// tb_watchdog_reset_wakeup_timer: self-checking bench for wdrt_top.
// assumes a short tick divider so every time-out fits the run.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_watchdog_reset_wakeup_timer;
  localparam int T = 4;
  logic mclk_i = 0;
  logic rst_b_i = 0;
  logic ctrl_wr_i = 0;
  logic [31:0] ctrl_wdata_i = 32'h0;
  logic power_down_i = 0;
  logic [31:0] ctrl_rdata_o;
  logic irq_o;
  logic cpu_reset_o;
  logic wakeup_o;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int c;
  logic [2:0] sel;
  // rows: interval code, ticks from clear to time-out
  int rows[5][2] = '{'{0, 16}, '{1, 64}, '{2, 256}, '{3, 1024},
    '{4, 4096}};
  always #4 mclk_i = ~mclk_i;
  wdrt_top #(.TICK_DIV(T)) wdrt_top_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .ctrl_wr_i(ctrl_wr_i),
    .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
    .power_down_i(power_down_i), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o),
    .wakeup_o(wakeup_o)
  );
  task automatic wr(input logic [31:0] d);
    @(posedge mclk_i);
    ctrl_wr_i <= 1'b1;
    ctrl_wdata_i <= d;
    @(posedge mclk_i);
    ctrl_wr_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    `CHK({ctrl_rdata_o, irq_o, cpu_reset_o, wakeup_o}, 35'h0)
    rst_b_i <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      sel = 3'(rows[i][0]);
      wr(32'hC1 | (32'(sel) << 8));
      `CHK({ctrl_rdata_o[10:7], ctrl_rdata_o[0]}, {sel, 2'b10})
      for (c = 0; c < 20000 && irq_o !== 1'b1; c++) @(posedge mclk_i);
      `CHK(c >= rows[i][1] * T - T && c < rows[i][1] * T, 1'b1)
      wr(32'h08);
    end
    wr(32'hC1);
    repeat (10)
    begin
      repeat (8 * T) @(posedge mclk_i);
      wr(32'hC1);
    end
    `CHK({irq_o, ctrl_rdata_o[3]}, 2'b00)
    for (c = 0; c < 200 && irq_o !== 1'b1; c++) @(posedge mclk_i);
    for (c = 0; c < 8000 && cpu_reset_o !== 1'b1; c++) @(posedge mclk_i);
    `CHK(c, 1024 * T)
    @(posedge mclk_i);
    `CHK({cpu_reset_o, ctrl_rdata_o[2]}, 2'b11)
    for (c = 0; c < 400 && cpu_reset_o !== 1'b0; c++) @(posedge mclk_i);
    // first reset cycle has passed before this loop starts
    `CHK(c, 63 * T - 1)
    repeat (2) @(posedge mclk_i);
    `CHK(ctrl_rdata_o[2], 1'b1)
    wr(32'h00);
    `CHK(ctrl_rdata_o[3:2], 2'b11)
    wr(32'h0C);
    `CHK(ctrl_rdata_o[3:2], 2'b00)
    // time-out while awake must not wake
    wr(32'h91);
    for (c = 0; c < 100 && wakeup_o !== 1'b1; c++) @(posedge mclk_i);
    `CHK(c, 100)
    power_down_i <= 1'b1;
    wr(32'h91);
    for (c = 0; c < 200 && wakeup_o !== 1'b1; c++) @(posedge mclk_i);
    `CHK(c < 200, 1'b1)
    power_down_i <= 1'b0;
    wr(32'h08);
    // long enough for an unaborted grace to end in a cpu reset
    repeat (1024 * T + 300) @(posedge mclk_i);
    `CHK({irq_o, cpu_reset_o, ctrl_rdata_o}, 34'h0)
    wr(32'hC1);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    `CHK({ctrl_rdata_o, irq_o, cpu_reset_o, wakeup_o}, 35'h0)
    rst_b_i <= 1'b1;
    repeat (200) @(posedge mclk_i);
    `CHK({irq_o, ctrl_rdata_o[7]}, 2'b00)
    close_out();
  end
endmodule
